// [pkg/fpsk_defs.vh]
// register offsets, field positions, reset values and key codes of the flash select/key block
`ifndef FPSK_DEFS_VH
`define FPSK_DEFS_VH

`define FPSK_OFF_PROG_SEL 12'h000
`define FPSK_OFF_ERASE_SEL 12'h004
`define FPSK_OFF_KEY 12'h008
`define FPSK_OFF_ARRAY_SEL 12'h00c
`define FPSK_OFF_CODE_CTRL 12'h010
`define FPSK_OFF_STATUS 12'h014

`define FPSK_ROUTINE_BIT 0
`define FPSK_DL_REQ_BIT 0
`define FPSK_ST_DL_ENABLE_BIT 0
`define FPSK_ST_PE_ENABLE_BIT 1
`define FPSK_ST_USER_BOOT_BIT 2

`define FPSK_KEY_RESET 8'h00
`define FPSK_KEY_DOWNLOAD 8'ha5
`define FPSK_KEY_PROG_ERASE 8'h5a
`define FPSK_ARRAY_USER_BOOT 8'haa
`define FPSK_ARRAY_USER 8'h00
`define FPSK_SEL_RESET 8'h00

`define FPSK_MODE_USER_PROG 2'h0
`define FPSK_MODE_BOOT 2'h1
`define FPSK_MODE_PROGRAMMER 2'h2
`define FPSK_MODE_USER_BOOT 2'h3

`define FPSK_MODE_SETTLE 2'h2

`endif

// [design/fpsk_flash_select_key.v]
// flash routine select, unlock key and memory array select registers on ahb-lite
`timescale 1ns/1ps
`include "fpsk_defs.vh"

module fpsk_flash_select_key (
    // ahb-lite slave
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    // operating mode straps, from pins
    input wire [1:0] boot_mode,
    // download engine
    input wire download_done,
    output wire download_request,
    output wire program_routine_bit,
    output wire erase_routine_bit,
    // flash array control
    output wire prog_erase_enable,
    output wire user_boot_selected
);

    reg [1:0] mode_meta_reg;
    reg [1:0] mode_sync_reg;
    reg [1:0] mode_reg;
    reg mode_captured_reg;
    reg array_init_reg;
    reg [7:0] key_reg;
    reg [7:0] array_sel_reg;
    reg prog_sel_reg;
    reg erase_sel_reg;
    reg dl_req_reg;
    reg wr_pending_reg;
    reg [11:0] wr_addr_reg;
    wire wr_req;
    wire rd_req;
    wire [7:0] wbyte;
    wire dl_set_ok;
    wire boot_sel_allowed;
    reg [31:0] rdata_next;
    reg [1:0] settle_reg;
    reg [1:0] settle_next;
    reg [1:0] mode_next;
    reg mode_captured_next;
    reg array_init_next;
    reg [7:0] key_next;
    reg [7:0] array_sel_next;
    reg prog_sel_next;
    reg erase_sel_next;
    reg dl_req_next;
    reg wr_pending_next;
    reg [11:0] wr_addr_next;
    reg [31:0] hrdata_next;
    wire wr_prog;
    wire wr_erase;
    wire wr_key;
    wire wr_array;
    wire wr_code;
    wire settled;
    wire [7:0] array_reset_value;
    wire [7:0] array_write_value;
    wire boot_value_written;
    wire [31:0] status_word;

    function sel_hit;
        input [11:0] addr;
        input [11:0] off;
        begin
            sel_hit = (addr == off);
        end
    endfunction

    // the same key comparison gates two separate permissions
    function key_match;
        input [7:0] key;
        input [7:0] code;
        begin
            key_match = (key == code);
        end
    endfunction

    function [31:0] zext_byte;
        input [7:0] value;
        begin
            zext_byte = {24'h00_0000, value};
        end
    endfunction

    // one routine select bit; a completing download beats a software write
    function routine_next;
        input current;
        input wr_hit;
        input wr_bit;
        input done;
        begin
            if (done) begin
                routine_next = 1'b0;
            end else if (wr_hit) begin
                routine_next = wr_bit;
            end else begin
                routine_next = current;
            end
        end
    endfunction

    function [7:0] array_value_for_mode;
        input [1:0] mode;
        begin
            case (mode)
                `FPSK_MODE_USER_BOOT: array_value_for_mode = `FPSK_ARRAY_USER_BOOT;
                default: array_value_for_mode = `FPSK_ARRAY_USER;
            endcase
        end
    endfunction

    function [31:0] status_pack;
        input dl;
        input pe;
        input ub;
        begin
            status_pack = 32'h0000_0000;
            status_pack[`FPSK_ST_DL_ENABLE_BIT] = dl;
            status_pack[`FPSK_ST_PE_ENABLE_BIT] = pe;
            status_pack[`FPSK_ST_USER_BOOT_BIT] = ub;
        end
    endfunction

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wr_req = hsel && hready && htrans[1] && hwrite;
    assign rd_req = hsel && hready && htrans[1] && !hwrite;
    assign wbyte = hwdata[7:0];

    // straps pass two flops before use; only the second stage feeds logic
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_meta_reg <= 2'h0;
            mode_sync_reg <= 2'h0;
        end else begin
            mode_meta_reg <= boot_mode;
            mode_sync_reg <= mode_meta_reg;
        end
    end

    // mode is latched once the strap has crossed both sync stages; the
    // array select reset value depends on it, so it cannot be an async
    // reset constant. straps must stay steady for the first few cycles.
    assign settled = (settle_reg == `FPSK_MODE_SETTLE);

    always @* begin
        settle_next = settle_reg;
        mode_next = mode_reg;
        mode_captured_next = mode_captured_reg;
        array_init_next = 1'b0;
        if (!settled) begin
            settle_next = settle_reg + 2'h1;
        end else if (!mode_captured_reg) begin
            mode_next = mode_sync_reg;
            mode_captured_next = 1'b1;
            array_init_next = 1'b1;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            settle_reg <= 2'h0;
            mode_reg <= `FPSK_MODE_USER_PROG;
            mode_captured_reg <= 1'b0;
            array_init_reg <= 1'b0;
        end else begin
            settle_reg <= settle_next;
            mode_reg <= mode_next;
            mode_captured_reg <= mode_captured_next;
            array_init_reg <= array_init_next;
        end
    end

    assign boot_sel_allowed = (mode_reg == `FPSK_MODE_BOOT) ||
                              (mode_reg == `FPSK_MODE_PROGRAMMER) ||
                              (mode_reg == `FPSK_MODE_USER_BOOT);
    assign dl_set_ok = key_match(key_reg, `FPSK_KEY_DOWNLOAD);

    // the address phase is held for the data phase, where hwdata stands
    always @* begin
        wr_pending_next = wr_req;
        wr_addr_next = wr_addr_reg;
        if (wr_req) begin
            wr_addr_next = haddr[11:0];
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pending_reg <= 1'b0;
            wr_addr_reg <= 12'h000;
        end else begin
            wr_pending_reg <= wr_pending_next;
            wr_addr_reg <= wr_addr_next;
        end
    end

    assign wr_prog = wr_pending_reg && sel_hit(wr_addr_reg, `FPSK_OFF_PROG_SEL);
    assign wr_erase = wr_pending_reg && sel_hit(wr_addr_reg, `FPSK_OFF_ERASE_SEL);
    assign wr_key = wr_pending_reg && sel_hit(wr_addr_reg, `FPSK_OFF_KEY);
    assign wr_array = wr_pending_reg && sel_hit(wr_addr_reg, `FPSK_OFF_ARRAY_SEL);
    assign wr_code = wr_pending_reg && sel_hit(wr_addr_reg, `FPSK_OFF_CODE_CTRL);

    // any byte is stored; only the two codes carry meaning
    always @* begin
        key_next = key_reg;
        if (wr_key) begin
            key_next = wbyte;
        end
    end

    assign array_reset_value = array_value_for_mode(mode_reg);
    assign boot_value_written = (wbyte == `FPSK_ARRAY_USER_BOOT);
    // user-boot value refused in user programming mode; stores the user array
    assign array_write_value = (boot_value_written && !boot_sel_allowed) ?
                               `FPSK_ARRAY_USER : wbyte;

    // a write in the load cycle wins; a write landing before that cycle is overwritten by the load
    always @* begin
        array_sel_next = array_sel_reg;
        if (array_init_reg) begin
            array_sel_next = array_reset_value;
        end
        if (wr_array) begin
            array_sel_next = array_write_value;
        end
    end

    // only bit 0 of each routine select is stored; bits 7..1 read zero
    always @* begin
        prog_sel_next = routine_next(prog_sel_reg, wr_prog,
                                     wbyte[`FPSK_ROUTINE_BIT], download_done);
        erase_sel_next = routine_next(erase_sel_reg, wr_erase,
                                      wbyte[`FPSK_ROUTINE_BIT], download_done);
    end

    // completion wins over a same-cycle request write
    always @* begin
        dl_req_next = dl_req_reg;
        if (download_done) begin
            dl_req_next = 1'b0;
        end else if (wr_code && wbyte[`FPSK_DL_REQ_BIT] && dl_set_ok) begin
            dl_req_next = 1'b1;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            key_reg <= `FPSK_KEY_RESET;
        end else begin
            key_reg <= key_next;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            array_sel_reg <= `FPSK_ARRAY_USER;
        end else begin
            array_sel_reg <= array_sel_next;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prog_sel_reg <= 1'b0;
        end else begin
            prog_sel_reg <= prog_sel_next;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            erase_sel_reg <= 1'b0;
        end else begin
            erase_sel_reg <= erase_sel_next;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dl_req_reg <= 1'b0;
        end else begin
            dl_req_reg <= dl_req_next;
        end
    end

    // request bit is write-only and reads zero; its state shows in status
    assign status_word = status_pack(dl_req_reg, prog_erase_enable, user_boot_selected);

    always @* begin
        rdata_next = 32'h0000_0000;
        case (haddr[11:0])
            `FPSK_OFF_PROG_SEL: rdata_next = {31'h0000_0000, prog_sel_reg};
            `FPSK_OFF_ERASE_SEL: rdata_next = {31'h0000_0000, erase_sel_reg};
            `FPSK_OFF_KEY: rdata_next = zext_byte(key_reg);
            `FPSK_OFF_ARRAY_SEL: rdata_next = zext_byte(array_sel_reg);
            `FPSK_OFF_STATUS: rdata_next = status_word;
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    // read data is captured at the address edge and stands until the next read
    always @* begin
        hrdata_next = hrdata;
        if (rd_req) begin
            hrdata_next = rdata_next;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else begin
            hrdata <= hrdata_next;
        end
    end

    assign download_request = dl_req_reg;
    assign program_routine_bit = prog_sel_reg;
    assign erase_routine_bit = erase_sel_reg;
    assign prog_erase_enable = key_match(key_reg, `FPSK_KEY_PROG_ERASE);
    assign user_boot_selected = (array_sel_reg == `FPSK_ARRAY_USER_BOOT);

endmodule // fpsk_flash_select_key

// [sim/fpsk_fsk_monitor.sv]
// assertion checker for the flash select and key block
`timescale 1ns/1ps
module fpsk_fsk_monitor (
    // bus
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    // straps and download engine
    input wire [1:0] boot_mode,
    input wire download_done,
    input wire download_request,
    input wire program_routine_bit,
    input wire erase_routine_bit,
    // flash control
    input wire prog_erase_enable,
    input wire user_boot_selected
);
    reg wr_p, aw, ad;
    reg [11:0] a_p;
    reg [7:0] k;
    wire k_dl = k == 8'ha5;
    // shadow of the key, so the enables can be tied to what software wrote
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_p <= 1'b0;
            aw <= 1'b0;
            k <= 8'h00;
        end else begin
            wr_p <= hsel && htrans[1] && hwrite;
            aw <= wr_p && a_p == 12'h00c;
            if (wr_p && a_p == 12'h008) k <= hwdata[7:0];
        end
    end
    always @(posedge hclk) begin
        a_p <= haddr[11:0];
        ad <= hwdata[7:0] == 8'haa;
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_PE_KEY: assert property (prog_erase_enable == (k == 8'h5a)) else $error("pe key");
    AST_PROG_CLR: assert property (download_done |=> !program_routine_bit) else $error("p clr");
    AST_ERA_CLR: assert property (download_done |=> !erase_routine_bit) else $error("e clr");
    AST_REQ_CLR: assert property (download_done |=> !download_request) else $error("r clr");
    AST_REQ_KEY: assert property ($rose(download_request) |-> $past(k_dl)) else $error("r key");
    AST_NO_UB: assert property (boot_mode == 2'h0 && $past(boot_mode, 4) == 2'h0
        |-> !user_boot_selected) else $error("ub mode0");
    AST_ARR_WR: assert property (aw |-> user_boot_selected == (ad && boot_mode != 2'h0))
        else $error("ub write");
    AST_ARR_RST: assert property ($rose(hresetn) |-> ##5 user_boot_selected
        == (boot_mode == 2'h3)) else $error("ub reset");
    cover property (download_done && download_request);
    cover property (aw && ad);
    cover property ($rose(prog_erase_enable));
endmodule // fpsk_fsk_monitor
bind fpsk_flash_select_key fpsk_fsk_monitor mon (.*);

// [sim/fpsk_flash_select_key_tb_top.sv]
// self-checking bench for the flash select and key block
`timescale 1ns/1ps
module fpsk_flash_select_key_tb_top;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, download_done = 0, rdp = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
    logic [1:0] htrans = 0, boot_mode = 0;
    logic [2:0] hsize = 3'h2;
    wire hreadyout, hresp, download_request, program_routine_bit, erase_routine_bit;
    wire prog_erase_enable, user_boot_selected;
    logic [31:0] q[$];
    int n_mismatch = 0, n_checks = 0;
    always #2 hclk = ~hclk;
    fpsk_flash_select_key uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .boot_mode(boot_mode),
        .download_done(download_done), .download_request(download_request),
        .program_routine_bit(program_routine_bit), .erase_routine_bit(erase_routine_bit),
        .prog_erase_enable(prog_erase_enable), .user_boot_selected(user_boot_selected)
    );
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // bounded wait for hready; a hang ends the run as a mismatch
    task automatic wt;
        int i;
        i = 0;
        do begin @(posedge hclk); i++; end while (hreadyout !== 1'b1 && i < 20);
        if (hreadyout !== 1'b1) begin n_mismatch++; test_done; end
    endtask
    task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsel <= 1'b1;
        wt;
        htrans <= 2'h0;
        hwdata <= d;
        rdp <= !w;
        wt;
        rdp <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        q.push_back(e);
        xf(1'b0, a, 32'h0);
    endtask
    // straps held steady across reset so the init load sees one mode
    task automatic rst(input logic [1:0] m);
        hresetn <= 1'b0;
        boot_mode <= m;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (6) @(posedge hclk);
    endtask
    always @(posedge hclk) if (rdp) chk(hrdata, q.pop_front());
    initial begin
        r = $urandom(32'h4c6ab0de);
        rst(2'h3);
        chk({30'h0, hresp, hreadyout}, 32'h1);
        rd(12'h00c, 32'haa);
        rd(12'h014, 32'h4);
        rd(12'h008, 32'h0);
        rst(2'h0);
        rd(12'h00c, 32'h0);
        xf(1'b1, 12'h00c, 32'haa);
        rd(12'h00c, 32'h0);
        rst(2'h2);
        xf(1'b1, 12'h00c, 32'haa);
        rd(12'h00c, 32'haa);
        rst(2'h1);
        xf(1'b1, 12'h00c, 32'haa);
        rd(12'h014, 32'h4);
        r = $urandom;
        if (r[7:0] == 8'haa) r = 32'h55;
        xf(1'b1, 12'h00c, r);
        rd(12'h00c, {24'h0, r[7:0]});
        for (logic [11:0] a = 0; a < 8; a += 4) begin
            r = $urandom;
            xf(1'b1, a, r);
            rd(a, r & 32'h1);
        end
        r = $urandom;
        if (r[7:0] == 8'ha5 || r[7:0] == 8'h5a) r = 32'h11;
        xf(1'b1, 12'h008, r);
        xf(1'b1, 12'h010, 32'h1);
        rd(12'h014, 32'h0);
        xf(1'b1, 12'h000, 32'hff);
        xf(1'b1, 12'h004, 32'hff);
        xf(1'b1, 12'h008, 32'ha5);
        xf(1'b1, 12'h010, 32'h1);
        rd(12'h014, 32'h1);
        chk({29'h0, download_request, program_routine_bit, erase_routine_bit}, 32'h7);
        download_done <= 1'b1;
        @(posedge hclk);
        download_done <= 1'b0;
        rd(12'h014, 32'h0);
        rd(12'h000, 32'h0);
        rd(12'h004, 32'h0);
        xf(1'b1, 12'h008, 32'h5a);
        rd(12'h014, 32'h2);
        rd(12'h010, 32'h0);
        xf(1'b1, 12'h040, 32'hff);
        rd(12'h040, 32'h0);
        repeat (2) @(posedge hclk);
        test_done;
    end
endmodule // fpsk_flash_select_key_tb_top
